/* afc_cfg.svh */
// Address map, field positions and timing figures of the FIFO host controller
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define AFC_OFF_CMD      8'h00
`define AFC_OFF_CFG      8'h04
`define AFC_OFF_WDATA    8'h08
`define AFC_OFF_RDATA    8'h0C
`define AFC_OFF_STATUS   8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AFC_CMD_PUSH     0
`define AFC_CMD_POP      1
`define AFC_CMD_INIT     2
`define AFC_CMD_REPLAY   3
`define AFC_CFG_LEAD     0
`define AFC_CFG_DEPTH    1
`define AFC_ST_BUSY      0
`define AFC_ST_FULL      1
`define AFC_ST_EMPTY     2
`define AFC_ST_HALF      3
`define AFC_ST_RVALID    4
`define AFC_ST_REFUSED   5
`define AFC_ST_INITED    6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AFC_WORD_W       9
`define AFC_CFG_RST      2'h0
`define AFC_WDATA_RST    9'h000

// ----------------------------------------------------------------------------
// Timing figures in ns and the clock rate
// ----------------------------------------------------------------------------
`define AFC_CLK_MHZ      10
`define AFC_T_STROBE_NS  15
`define AFC_T_RECOVER_NS 10
`define AFC_T_INIT_NS    25
`define AFC_T_RINIT_NS   15
// Least time in ns to whole cycles, never below one
`define AFC_CYC(ns) ((((ns) * `AFC_CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `AFC_CLK_MHZ + 999) / 1000))

`endif

/* afc_fifo_model.sv */
// Behavioural model of the asynchronous ring buffer device
`timescale 1ns/1ns
module afc_fifo_model #(
   parameter int DEPTH = 256
) (
   input wire logic       init_n,
   input wire logic       push_pulse_n,
   input wire logic       take_pulse_n,
   input wire logic       replay_pulse_n,
   input wire logic       chain_pulse_in,
   input wire logic [8:0] data_in_bus,
   output logic           full_ind_n,
   output logic           empty_ind_n,
   output logic           half_ind_n,
   output logic [8:0]     data_out_bus
);
   logic [8:0] mem [DEPTH];
   logic [8:0] last_q = 9'h000;
   int         wr = 0;
   int         rd = 0;
   int         cnt = 0;
   bit         wok = 0;
   bit         rok = 0;
   // Initialise clears both pointers
   always @(negedge init_n) begin
      wr = 0;
      rd = 0;
      cnt = 0;
   end
   // Strobe counts only if its flag allowed it at the fall
   always @(negedge push_pulse_n) wok = init_n && full_ind_n;
   always @(negedge take_pulse_n) rok = init_n && empty_ind_n;
   // Word stored on the push rise, ring wrap
   always @(posedge push_pulse_n) begin
      if (wok) begin
         mem[wr] = data_in_bus;
         wr = (wr + 1) % DEPTH;
         cnt++;
      end
      wok = 0;
   end
   // Read pointer advances on the pop rise
   always @(posedge take_pulse_n) begin
      if (rok) begin
         last_q = mem[rd];
         rd = (rd + 1) % DEPTH;
         cnt--;
      end
      rok = 0;
   end
   // Replay moves only the read pointer
   always @(negedge replay_pulse_n) begin
      if (init_n && !chain_pulse_in) begin
         rd = 0;
         cnt = wr;
      end
   end
   // Flags from occupancy
   assign full_ind_n = cnt != DEPTH;
   assign empty_ind_n = cnt != 0;
   // Shared pin: chain pulse at the last location in depth mode, else half-full
   assign half_ind_n = chain_pulse_in ? !(!push_pulse_n && wok && wr == DEPTH - 1)
                                      : cnt <= DEPTH / 2;
   // Word only while popping, else inverse of last
   assign data_out_bus = (!take_pulse_n && rok) ? mem[rd] : ~last_q;
endmodule // afc_fifo_model

/* afc_host.sv */
// Host controller that drives an asynchronous ring FIFO through its pins
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "afc_cfg.svh"

module afc_host
   import afc_pkg::*;
#(
   parameter int NDEV   = 1,
   parameter int ADDR_W = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NDEV-1:0]   full_ind_n,
   input  wire logic [NDEV-1:0]   empty_ind_n,
   input  wire logic              half_ind_n,
   input  wire logic [8:0]        data_out_bus,
   output afc_dev_out_t           dev_out
);

   // ----------------------------------------------------------------------------
   // Strobe timing in cycles
   // ----------------------------------------------------------------------------
   localparam int STB_CYC   = `AFC_CYC(`AFC_T_STROBE_NS);
   localparam int REC_CYC   = `AFC_CYC(`AFC_T_RECOVER_NS);
   localparam int INIT_CYC  = `AFC_CYC(`AFC_T_INIT_NS);
   localparam int RINIT_CYC = `AFC_CYC(`AFC_T_RINIT_NS);

   afc_op_t                op_q;
   afc_op_t                op_d;
   logic [1:0]             cfg_q;
   logic [`AFC_WORD_W-1:0] wdata_q;
   logic [`AFC_WORD_W-1:0] push_data_q;
   logic [`AFC_WORD_W-1:0] rdata_q;
   logic                   rvalid_q;
   logic                   refused_q;
   logic                   inited_q;
   logic [31:0]            prdata_q;

   // ----------------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------------
   wire setup_ph  = psel & ~penable;
   wire access_ph = psel & penable;
   wire sel_cmd   = (paddr == ADDR_W'(`AFC_OFF_CMD));
   wire sel_cfg   = (paddr == ADDR_W'(`AFC_OFF_CFG));
   wire sel_wdata = (paddr == ADDR_W'(`AFC_OFF_WDATA));
   wire sel_rdata = (paddr == ADDR_W'(`AFC_OFF_RDATA));
   wire sel_stat  = (paddr == ADDR_W'(`AFC_OFF_STATUS));
   wire mapped    = sel_cmd | sel_cfg | sel_wdata | sel_rdata | sel_stat;
   wire wr_ok     = access_ph & pwrite & mapped;
   wire rd_ok     = access_ph & ~pwrite & mapped;

   // ----------------------------------------------------------------------------
   // Device flags seen by the host
   // ----------------------------------------------------------------------------
   wire full_any   = ~&full_ind_n;
   wire empty_any  = ~&empty_ind_n;
   wire depth_mode = cfg_q[`AFC_CFG_DEPTH];
   wire half_seen  = ~depth_mode & ~half_ind_n;

   // ----------------------------------------------------------------------------
   // Strobe generators
   // ----------------------------------------------------------------------------
   logic push_n;
   logic push_busy;
   logic take_n;
   logic take_last;
   logic take_busy;
   logic init_n;
   logic init_busy;
   logic replay_n;
   logic replay_busy;

   wire busy = (op_q != AFC_OP_IDLE) | push_busy | take_busy | init_busy | replay_busy;

   // Command decode and acceptance
   wire cmd_wr     = wr_ok & sel_cmd;
   wire req_push   = cmd_wr & pwdata[`AFC_CMD_PUSH];
   wire req_pop    = cmd_wr & pwdata[`AFC_CMD_POP];
   wire req_init   = cmd_wr & pwdata[`AFC_CMD_INIT];
   wire req_replay = cmd_wr & pwdata[`AFC_CMD_REPLAY];
   wire go_init    = req_init & ~busy;
   wire go_push    = req_push & ~req_init & ~busy & inited_q & ~full_any;
   wire go_pop     = req_pop & ~req_init & ~req_push & ~busy & inited_q
                     & ~empty_any;
   wire go_replay  = req_replay & ~req_init & ~req_push & ~req_pop & ~busy
                     & inited_q & ~depth_mode;
   wire any_req    = req_push | req_pop | req_init | req_replay;
   wire refuse     = any_req & ~(go_init | go_push | go_pop | go_replay);

   // Push strobe, data held from before fall to after rise
   afc_pulse #(
      .LOW_CYC  (STB_CYC),
      .HIGH_CYC (REC_CYC)
   ) u_push (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .start    (op_q == AFC_OP_PUSH),
      .strobe_n (push_n),
      .last_low (),
      .busy     (push_busy)
   );

   // Pop strobe, word sampled in its last low cycle
   afc_pulse #(
      .LOW_CYC  (STB_CYC),
      .HIGH_CYC (REC_CYC)
   ) u_take (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .start    (op_q == AFC_OP_POP),
      .strobe_n (take_n),
      .last_low (take_last),
      .busy     (take_busy)
   );

   // Initialise pulse, strobes stay high through recovery
   afc_pulse #(
      .LOW_CYC  (INIT_CYC),
      .HIGH_CYC (RINIT_CYC)
   ) u_init (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .start    (op_q == AFC_OP_INIT),
      .strobe_n (init_n),
      .last_low (),
      .busy     (init_busy)
   );

   // Replay pulse, read pointer only
   afc_pulse #(
      .LOW_CYC  (STB_CYC),
      .HIGH_CYC (REC_CYC)
   ) u_replay (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .start    (op_q == AFC_OP_REPLAY),
      .strobe_n (replay_n),
      .last_low (),
      .busy     (replay_busy)
   );

   // ----------------------------------------------------------------------------
   // Operation launch: one cycle of op, then the strobe runs alone
   // ----------------------------------------------------------------------------
   always_comb begin
      op_d = AFC_OP_IDLE;
      if (go_init) begin
         op_d = AFC_OP_INIT;
      end else if (go_push) begin
         op_d = AFC_OP_PUSH;
      end else if (go_pop) begin
         op_d = AFC_OP_POP;
      end else if (go_replay) begin
         op_d = AFC_OP_REPLAY;
      end
   end

   // Operation and word registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_q        <= AFC_OP_IDLE;
         push_data_q <= `AFC_WDATA_RST;
         rdata_q     <= `AFC_WDATA_RST;
      end else if (ce) begin
         op_q <= op_d;
         if (go_push) begin
            push_data_q <= wdata_q;
         end
         if (take_last) begin
            rdata_q <= data_out_bus;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------------
   wire clr_rvalid  = rd_ok & sel_rdata;
   wire clr_refused = wr_ok & sel_stat & pwdata[`AFC_ST_REFUSED];

   // Configuration and write word
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q   <= `AFC_CFG_RST;
         wdata_q <= `AFC_WDATA_RST;
      end else if (ce) begin
         if (wr_ok & sel_cfg & ~busy) begin
            cfg_q <= pwdata[1:0];
         end
         if (wr_ok & sel_wdata) begin
            wdata_q <= pwdata[`AFC_WORD_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Initialise tracking: pending from acceptance until the strobe has recovered
   // ----------------------------------------------------------------------------
   logic init_pend_q;
   logic init_pend_d;
   wire  init_done = init_pend_q & (op_q == AFC_OP_IDLE) & ~init_busy;

   // Pending flag, set on acceptance and cleared once recovery ends
   assign init_pend_d = go_init | (init_pend_q & ~init_done);

   // Pending flag flop
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_pend_q <= 1'b0;
      end else if (ce) begin
         init_pend_q <= init_pend_d;
      end
   end

   // Sticky flags, set wins over clear except for inited, where a new initialise clears it
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q  <= 1'b0;
         refused_q <= 1'b0;
         inited_q  <= 1'b0;
      end else if (ce) begin
         rvalid_q  <= take_last | (rvalid_q & ~clr_rvalid);
         refused_q <= refuse | (refused_q & ~clr_refused);
         if (go_init) begin
            inited_q <= 1'b0;
         end else if (init_done) begin
            inited_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Read data path
   // ----------------------------------------------------------------------------
   afc_status_t stat;
   assign stat.inited  = inited_q;
   assign stat.refused = refused_q;
   assign stat.rvalid  = rvalid_q;
   assign stat.half    = half_seen;
   assign stat.empty   = empty_any;
   assign stat.full    = full_any;
   assign stat.busy    = busy;

   wire [31:0] rd_mux = sel_cfg   ? {30'h0, cfg_q} :
                        sel_wdata ? {23'h0, wdata_q} :
                        sel_rdata ? {23'h0, rdata_q} :
                        sel_stat  ? {25'h0, stat} : 32'h0;

   // Read word captured in the setup cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q <= 32'h0;
      end else if (ce && setup_ph) begin
         prdata_q <= rd_mux;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~mapped;

   // ----------------------------------------------------------------------------
   // Pins toward the device
   // ----------------------------------------------------------------------------
   assign dev_out.init_n             = init_n;
   assign dev_out.push_pulse_n       = push_n;
   assign dev_out.take_pulse_n       = take_n;
   assign dev_out.replay_pulse_n     = replay_n;
   assign dev_out.lead_device_select = cfg_q[`AFC_CFG_LEAD];
   assign dev_out.data_in_bus        = push_data_q;

endmodule // afc_host

/* afc_host_properties.sv */
// Port checks for the FIFO host controller
`timescale 1ns/1ns
`include "afc_cfg.svh"
module afc_host_properties
   import afc_pkg::*;
#(
   parameter int NDEV   = 1,
   parameter int ADDR_W = 8
) (
   input wire logic              sys_clk,
   input wire logic              reset_n,
   input wire logic              ce,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [NDEV-1:0]   full_ind_n,
   input wire logic [NDEV-1:0]   empty_ind_n,
   input wire logic              half_ind_n,
   input wire logic [8:0]        data_out_bus,
   input wire afc_dev_out_t      dev_out
);
   // ----------
   // Helpers
   // ----------
   logic seen_q;
   logic mapped;
   // Set once an initialise strobe was seen
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) seen_q <= 1'b0;
      else if (!dev_out.init_n) seen_q <= 1'b1;
   end
   // Decoded register window
   assign mapped = paddr == `AFC_OFF_CMD || paddr == `AFC_OFF_CFG || paddr == `AFC_OFF_WDATA
                   || paddr == `AFC_OFF_RDATA || paddr == `AFC_OFF_STATUS;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence push_go; $fell(dev_out.push_pulse_n); endsequence
   sequence pop_go; $fell(dev_out.take_pulse_n); endsequence
   sequence idle_st; dev_out.push_pulse_n && dev_out.take_pulse_n; endsequence
   // ----------
   // Assertions
   // ----------
   a_push_not_full: assert property (push_go |-> &full_ind_n)
      else $error("push strobe while full");
   a_pop_not_empty: assert property (pop_go |-> &empty_ind_n)
      else $error("pop strobe while empty");
   a_op_after_init: assert property ($fell(dev_out.push_pulse_n) || $fell(dev_out.take_pulse_n) |-> seen_q)
      else $error("strobe before initialise");
   a_init_release: assert property ($rose(dev_out.init_n) |-> idle_st ##1 idle_st)
      else $error("strobes active around initialise release");
   a_init_short: assert property ($fell(dev_out.init_n) |=> dev_out.init_n)
      else $error("initialise strobe length wrong");
   a_push_width: assert property (push_go |=> dev_out.push_pulse_n [*2])
      else $error("push strobe width or recovery wrong");
   a_data_hold: assert property (push_go |-> $stable(dev_out.data_in_bus) [*2])
      else $error("write word moved around push strobe");
   a_replay_idle: assert property (!dev_out.replay_pulse_n |-> idle_st)
      else $error("strobe active during replay");
   a_apb_answer: assert property (psel && penable |-> pready && pslverr == !mapped)
      else $error("bus answer or error wrong");
endmodule // afc_host_properties

bind afc_host afc_host_properties #(.NDEV(NDEV), .ADDR_W(ADDR_W)) u_props (
   .sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .full_ind_n(full_ind_n), .empty_ind_n(empty_ind_n), .half_ind_n(half_ind_n),
   .data_out_bus(data_out_bus), .dev_out(dev_out)
);

/* afc_pkg.sv */
// Types shared by the FIFO host controller files
package afc_pkg;

   // ----------------------------------------------------------------------------
   // Operation in progress
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      AFC_OP_IDLE   = 3'b000,
      AFC_OP_INIT   = 3'b001,
      AFC_OP_PUSH   = 3'b010,
      AFC_OP_POP    = 3'b011,
      AFC_OP_REPLAY = 3'b100
   } afc_op_t;

   // ----------------------------------------------------------------------------
   // Pins driven toward the buffer device
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic       init_n;
      logic       push_pulse_n;
      logic       take_pulse_n;
      logic       replay_pulse_n;
      logic       lead_device_select;
      logic [8:0] data_in_bus;
   } afc_dev_out_t;

   // ----------------------------------------------------------------------------
   // Status word fields
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic inited;
      logic refused;
      logic rvalid;
      logic half;
      logic empty;
      logic full;
      logic busy;
   } afc_status_t;

endpackage

/* afc_pulse.sv */
// Low-going strobe generator with a held-high recovery phase
`timescale 1ns/1ns
module afc_pulse #(
   parameter int LOW_CYC  = 1,
   parameter int HIGH_CYC = 1
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic ce,
   input  wire logic start,
   output logic      strobe_n,
   output logic      last_low,
   output logic      busy
);

   localparam int CW = 8;

   logic          low_q;
   logic          low_d;
   logic          rec_q;
   logic          rec_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          cnt_end;

   // ----------------------------------------------------------------------------
   // Phase sequencing
   // ----------------------------------------------------------------------------
   assign cnt_end  = (cnt_q == '0);
   assign last_low = low_q & cnt_end;
   assign busy     = low_q | rec_q;
   assign low_d    = start & ~busy ? 1'b1 : (low_q & ~cnt_end);
   assign rec_d    = last_low ? 1'b1 : (rec_q & ~cnt_end);
   assign cnt_d    = (start & ~busy) ? CW'(LOW_CYC - 1) :
                     last_low        ? CW'(HIGH_CYC - 1) :
                     (busy & ~cnt_end) ? cnt_q - 1'b1 : cnt_q;

   // Phase and counter flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_q    <= 1'b0;
         rec_q    <= 1'b0;
         cnt_q    <= '0;
         strobe_n <= 1'b1;
      end else if (ce) begin
         low_q    <= low_d;
         rec_q    <= rec_d;
         cnt_q    <= cnt_d;
         strobe_n <= ~low_d;
      end
   end

endmodule // afc_pulse

/* test_afc_host.sv */
// Bench for the FIFO host controller with a buffer model
`timescale 1ns/1ns
`include "afc_cfg.svh"
module test_afc_host;
   import afc_pkg::*;
   localparam int DEPTH = 256;
   logic         sys_clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata;
   logic [31:0]  q;
   logic         pready, pslverr, full_n, empty_n, half_n, e;
   logic [8:0]   dout;
   afc_dev_out_t dev_out;
   int           miscompares = 0;
   int           samples_checked = 0;
   // Clock
   always #50 sys_clk = ~sys_clk;
   afc_host #(.NDEV(1), .ADDR_W(8)) i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .full_ind_n(full_n), .empty_ind_n(empty_n), .half_ind_n(half_n), .data_out_bus(dout), .dev_out(dev_out)
   );
   afc_fifo_model #(.DEPTH(DEPTH)) u_dev (
      .init_n(dev_out.init_n), .push_pulse_n(dev_out.push_pulse_n), .take_pulse_n(dev_out.take_pulse_n),
      .replay_pulse_n(dev_out.replay_pulse_n), .chain_pulse_in(1'b0), .data_in_bus(dev_out.data_in_bus),
      .full_ind_n(full_n), .empty_ind_n(empty_n), .half_ind_n(half_n), .data_out_bus(dout)
   );
   // ----------
   // Tasks
   // ----------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] sv(logic i, logic r, logic h, logic m, logic f);
      return {25'h0, i, r, 1'b0, h, m, f, 1'b0};
   endfunction
   task automatic st(input logic [31:0] exp);
      apb(1'b0, `AFC_OFF_STATUS, 32'h0);
      check(q & 32'h6F, exp);
   endtask
   task automatic cmd(input logic [3:0] b);
      int n;
      n = 0;
      apb(1'b1, `AFC_OFF_CMD, {28'h0, b});
      q = 32'h1;
      while (q[`AFC_ST_BUSY] !== 1'b0 && n < 20) begin
         apb(1'b0, `AFC_OFF_STATUS, 32'h0);
         n++;
      end
      check({31'h0, q[`AFC_ST_BUSY]}, 32'h0);
   endtask
   task automatic push(input logic [8:0] d);
      apb(1'b1, `AFC_OFF_WDATA, {23'h0, d});
      cmd(4'h1);
   endtask
   task automatic pop(input logic [8:0] d);
      cmd(4'h2);
      check({31'h0, q[`AFC_ST_RVALID]}, 32'h1);
      apb(1'b0, `AFC_OFF_RDATA, 32'h0);
      check({23'h0, q[8:0]}, {23'h0, d});
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog
   initial begin
      #6000000;
      miscompares++;
      conclude;
   end
   // Test sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      apb(1'b0, `AFC_OFF_CFG, 32'h0);
      check(q, 32'h0);
      st(sv(0, 0, 0, 1, 0));
      cmd(4'h1);
      st(sv(0, 1, 0, 1, 0));
      apb(1'b1, `AFC_OFF_STATUS, 32'h20);
      cmd(4'h4);
      st(sv(1, 0, 0, 1, 0));
      cmd(4'h2);
      st(sv(1, 1, 0, 1, 0));
      apb(1'b1, `AFC_OFF_STATUS, 32'h20);
      $display("reset and refusal test done");
      push(9'h1AB);
      push(9'h054);
      pop(9'h1AB);
      pop(9'h054);
      for (int i = 0; i < DEPTH; i++) begin
         push(9'(i) ^ 9'h155);
         if (i == DEPTH / 2 - 1 || i == DEPTH / 2) st(sv(1, 0, i == DEPTH / 2, 0, 0));
      end
      st(sv(1, 0, 1, 0, 1));
      cmd(4'h1);
      st(sv(1, 1, 1, 0, 1));
      apb(1'b1, `AFC_OFF_STATUS, 32'h20);
      for (int i = 0; i < DEPTH; i++) begin
         pop(9'(i) ^ 9'h155);
         if (i == DEPTH / 2 - 2 || i == DEPTH / 2 - 1) st(sv(1, 0, i == DEPTH / 2 - 2, 0, 0));
      end
      st(sv(1, 0, 0, 1, 0));
      $display("fill and drain test done");
      cmd(4'h4);
      for (int i = 0; i < 3; i++) push(9'h0F0 + 9'(i));
      pop(9'h0F0);
      cmd(4'h8);
      pop(9'h0F0);
      pop(9'h0F1);
      $display("replay test done");
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, e}, 32'h1);
      apb(1'b1, `AFC_OFF_CFG, 32'h1);
      apb(1'b0, `AFC_OFF_CFG, 32'h0);
      check(q, 32'h1);
      check({31'h0, dev_out.lead_device_select}, 32'h1);
      apb(1'b1, `AFC_OFF_CFG, 32'h3);
      cmd(4'h8);
      st(sv(1, 1, 0, 0, 0));
      $display("register test done");
      conclude;
   end
endmodule // test_afc_host
